// ### bl_defines.vh
// constants for the bit, logic and call execution block
`ifndef BL_DEFINES_VH
`define BL_DEFINES_VH
`define BL_OP_NONE        3'h0
`define BL_OP_AND_IMM     3'h1
`define BL_OP_SET_BIT     3'h2
`define BL_OP_TEST_SKIP   3'h3
`define BL_OP_CALL        3'h4
`define BL_ACC_RESET      8'h00
`define BL_PC_RESET       10'h000
`define BL_FILE_DEPTH     64
`define BL_STACK_DEPTH    8
`define BL_SP_RESET       3'h0
`endif

// ### bl_core.v
// execution of and-immediate, set-bit, test-skip-if-clear and direct call
`timescale 1ns/100ps
`include "bl_defines.vh"
module bl_core (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_valid,
    input  wire [2:0]  i_op,
    input  wire [7:0]  i_imm,
    input  wire [5:0]  i_addr,
    input  wire [2:0]  i_bit,
    input  wire [1:0]  i_high_page_buffer,
    output reg         o_ready,
    output reg  [7:0]  o_work_register,
    output reg         o_zero,
    output reg  [9:0]  o_pc,
    output reg  [2:0]  o_sp,
    output reg  [9:0]  o_stack_top,
    output reg  [7:0]  o_file_data,
    output reg         o_skipping
);
    localparam ST_RUN  = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [7:0] file_q [0:`BL_FILE_DEPTH-1];
    reg [9:0] stack_q [0:`BL_STACK_DEPTH-1];
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] and_res;
    reg       busy_d;
    integer   k;

    // one-hot mask of the selected bit
    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = 8'h01 << sel;
        end
    endfunction

    wire take    = i_valid && (state_q == ST_RUN);
    wire bit_clr = (file_q[i_addr] & bit_mask(i_bit)) == 8'h00;

    // next state and result
    always @* begin
        and_res = o_work_register & i_imm;
        state_d = state_q;
        busy_d  = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (take && ((i_op == `BL_OP_CALL) || ((i_op == `BL_OP_TEST_SKIP) && bit_clr))) begin
                    state_d = ST_WAIT;
                    busy_d  = 1'b1;
                end
            end
            ST_WAIT: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // decoded strobes of the instruction taken this edge
    // each one is qualified by take, so nothing fires while
    // the sequencer spends the second cycle of a call or skip
    wire       do_and  = take && (i_op == `BL_OP_AND_IMM);
    wire       do_set  = take && (i_op == `BL_OP_SET_BIT);
    wire       do_skip = take && (i_op == `BL_OP_TEST_SKIP) && bit_clr;
    wire       do_call = take && (i_op == `BL_OP_CALL);
    wire [9:0] ret_addr = o_pc + 10'h001;
    wire [7:0] set_val  = file_q[i_addr] | bit_mask(i_bit);
    integer    m;

    // sequencer state: run accepts, wait spends the second cycle
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ready flag, low for the cycle after a call or taken skip
    // an instruction offered while ready is low is ignored
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ready <= 1'b1;
        end else begin
            o_ready <= ~busy_d;
        end
    end

    // work register and zero flag
    // only and-immediate touches them; set-bit, skip and call
    // leave the zero flag as it stands
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_work_register <= `BL_ACC_RESET;
            o_zero          <= 1'b0;
        end else if (do_and) begin
            o_work_register <= and_res;
            o_zero          <= (and_res == 8'h00);
        end
    end

    // program counter
    // a call jumps, a taken skip steps over the fetched word,
    // every other taken instruction steps by one
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pc <= `BL_PC_RESET;
        end else if (do_call) begin
            o_pc <= {i_high_page_buffer, i_imm};
        end else if (do_skip) begin
            o_pc <= o_pc + 10'h002;
        end else if (take) begin
            o_pc <= ret_addr;
        end
    end

    // skip pulse
    // high for the one cycle in which the discarded word
    // runs as a no-op; the sequencer holds ready low meanwhile
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_skipping <= 1'b0;
        end else begin
            o_skipping <= do_skip;
        end
    end

    // file registers
    // set-bit is the only writer inside this block; the other
    // bits of the addressed word keep their value
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (k = 0; k < `BL_FILE_DEPTH; k = k + 1) begin
                file_q[k] <= 8'h00;
            end
        end else if (do_set) begin
            file_q[i_addr] <= set_val;
        end
    end

    // file read-back
    // shows the addressed word as the instruction saw it, or the
    // updated word for set-bit, so the result stands until the next
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_file_data <= 8'h00;
        end else if (do_set) begin
            o_file_data <= set_val;
        end else if (take) begin
            o_file_data <= file_q[i_addr];
        end
    end

    // return-address stack
    // eight entries; the pointer wraps, so a ninth push
    // overwrites the oldest entry without warning
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (m = 0; m < `BL_STACK_DEPTH; m = m + 1) begin
                stack_q[m] <= `BL_PC_RESET;
            end
        end else if (do_call) begin
            stack_q[o_sp] <= ret_addr;
        end
    end

    // stack pointer and last pushed return address
    // the copy on the port saves a read port on the stack
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_sp        <= `BL_SP_RESET;
            o_stack_top <= `BL_PC_RESET;
        end else if (do_call) begin
            o_sp        <= o_sp + 3'h1;
            o_stack_top <= ret_addr;
        end
    end

    // limitations worth knowing
    // the call address takes only its low eight bits from the immediate, so the
    // page bits must be set up before the call is offered
    // a no-op opcode still advances the program counter
    // the zero flag is written by and-immediate alone here;
    // other writers of the status word sit outside this block
endmodule // bl_core

// ### bl_core_asserts.sv
// checker for the execution block ports
`timescale 1ns/100ps
module bl_core_asserts (
    input wire       i_clock, i_rst, i_valid, o_ready, o_zero, o_skipping,
    input wire [2:0] i_op, i_bit, o_sp,
    input wire [7:0] i_imm, o_work_register, o_file_data,
    input wire [1:0] i_high_page_buffer,
    input wire [9:0] o_pc, o_stack_top
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // an instruction is taken this edge
    wire t = i_valid && o_ready;
    property p_and; t && i_op == 3'h1 |=> o_work_register == ($past(o_work_register) & $past(i_imm))
        && o_zero == (o_work_register == 8'h00); endproperty
    a_and: assert property (p_and) else $error("and result wrong");
    property p_set; t && i_op == 3'h2 |=> o_file_data[$past(i_bit)] && $stable(o_zero); endproperty
    a_set: assert property (p_set) else $error("set bit wrong");
    property p_skip; t && i_op == 3'h3 |=> o_skipping == !o_file_data[$past(i_bit)]; endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_skcyc; o_skipping |-> !o_ready ##1 o_ready; endproperty
    a_skcyc: assert property (p_skcyc) else $error("skip length wrong");
    property p_push; t && i_op == 3'h4 |=> o_stack_top == $past(o_pc) + 10'h001 && o_sp == $past(o_sp) + 3'h1;
    endproperty
    a_push: assert property (p_push) else $error("push wrong");
    property p_pc; t && i_op == 3'h4 |=> o_pc == {$past(i_high_page_buffer), $past(i_imm)}; endproperty
    a_pc: assert property (p_pc) else $error("call target wrong");
    property p_call2; t && i_op == 3'h4 |=> !o_ready ##1 o_ready; endproperty
    a_call2: assert property (p_call2) else $error("call length wrong");
    property p_one; t && (i_op == 3'h1 || i_op == 3'h2) |=> o_ready; endproperty
    a_one: assert property (p_one) else $error("single cycle wrong");
    c_call: cover property (t && i_op == 3'h4);
    c_skip: cover property (o_skipping);
    c_set: cover property (t && i_op == 3'h2);
endmodule // bl_core_asserts
bind bl_core bl_core_asserts chk (.*);

// ### bl_core_bench.sv
// self-checking bench for the execution block
`timescale 1ns/100ps
module bl_core_bench;
    reg        i_clock = 0, i_rst = 1, i_valid = 0;
    reg  [2:0] i_op = 0, i_bit = 0, s;
    reg  [7:0] i_imm = 0;
    reg  [5:0] i_addr = 0;
    reg  [1:0] i_high_page_buffer = 0;
    wire       o_ready, o_zero, o_skipping;
    wire [7:0] o_work_register, o_file_data;
    wire [9:0] o_pc, o_stack_top;
    wire [2:0] o_sp;
    reg  [9:0] p;
    integer    n_fail = 0, num_checks = 0, j;
    bl_core uut (
        .i_clock            (i_clock),
        .i_rst              (i_rst),
        .i_valid            (i_valid),
        .i_op               (i_op),
        .i_imm              (i_imm),
        .i_addr             (i_addr),
        .i_bit              (i_bit),
        .i_high_page_buffer (i_high_page_buffer),
        .o_ready            (o_ready),
        .o_work_register    (o_work_register),
        .o_zero             (o_zero),
        .o_pc               (o_pc),
        .o_sp               (o_sp),
        .o_stack_top        (o_stack_top),
        .o_file_data        (o_file_data),
        .o_skipping         (o_skipping)
    );
    initial forever #20 i_clock = ~i_clock;
    task wrap_up; begin
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    end endtask
    task chk(input [9:0] got, input [9:0] exp); begin
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    end endtask
    // waits for ready, presents one instruction, returns after its edge
    task op(input [2:0] c, input [7:0] m, input [5:0] a, input [2:0] b); integer k; begin
        for (k = 0; o_ready !== 1'h1; k = k + 1) begin
            if (k == 9) begin n_fail = n_fail + 1; wrap_up; end
            @(negedge i_clock);
        end
        i_op = c; i_imm = m; i_addr = a; i_bit = b; i_valid = 1'h1;
        @(negedge i_clock);
    end endtask
    task t_and; begin
        op(3'h1, 8'hAF, 6'h00, 3'h0); chk(o_work_register, 10'h000);
        chk(o_zero, 10'h001);
    end endtask
    task t_set; begin
        op(3'h2, 8'h00, 6'h3F, 3'h7); chk(o_file_data, 10'h080);
        op(3'h2, 8'h00, 6'h3F, 3'h2); chk(o_file_data, 10'h084);
    end endtask
    task t_skip; begin
        op(3'h3, 8'h00, 6'h3F, 3'h2); chk(o_skipping, 10'h000);
        chk(o_ready, 10'h001);
        op(3'h3, 8'h00, 6'h3F, 3'h0); chk(o_skipping, 10'h001);
        chk(o_ready, 10'h000);
    end endtask
    task t_call; begin
        for (j = 0; j < 9; j = j + 1) begin
            i_high_page_buffer = j[1:0];
            op(3'h4, 8'hF0 + j[7:0], 6'h00, 3'h0); p = o_pc; s = o_sp;
            chk(o_pc, {j[1:0], 8'hF0 + j[7:0]});
            chk(o_ready, 10'h000);
        end
        p = o_pc; s = o_sp + 3'h1;
        op(3'h4, 8'h12, 6'h00, 3'h0); chk(o_stack_top, p + 10'h001);
        chk(o_sp, s);
    end endtask
    initial begin
        repeat (5) @(negedge i_clock);
        i_rst = 0;
        t_and; t_set; t_skip; t_call;
        i_valid = 0;
        wrap_up;
    end
endmodule // bl_core_bench
